/* File: rtl/status_reg_write_protection.sv */
// Purpose: Quad enable bit, status register protection state and the
//          nonvolatile to volatile protect copy at reset.
// Assumes: Commands come from the serial front end on the same clock;
//          i_srst is raised for power cycle, pin reset and soft reset.
// Notes:   Write protect and hold pins are synchronised here.
`timescale 1ns/10ps
module status_reg_write_protection
   import flash_protect_pkg::*;
(
   // Clock and reset
   input  wire logic     i_clock,
   input  wire logic     i_srst,
   // Pins, active low, asynchronous
   input  wire logic     i_wp_n,
   input  wire logic     i_hold_reset_n,
   // Decoded command from the serial front end
   input  wire logic     i_cmd_valid,
   input  wire logic [7:0] i_cmd_opcode,
   input  wire logic [7:0] i_cmd_data0,
   input  wire logic [7:0] i_cmd_data1,
   input  wire logic     i_cmd_two_bytes,
   input  wire logic [1:0] i_cmd_reg_sel,
   input  wire logic     i_write_enable_latch,
   // Nonvolatile copy of the protect state
   input  wire logic     i_nv_protect_upper,
   input  wire logic     i_nv_protect_lower,
   input  wire logic     i_nv_permanent_lock,
   // Configuration and status
   output logic [7:0]    o_status2,
   output logic          o_quad_io_enable,
   output logic          o_reg_protect_upper,
   output logic          o_reg_protect_lower,
   output logic          o_permanent_lock_flag,
   output logic          o_hold_reset_select,
   output protect_type_t o_protect_type,
   // Pin roles
   output logic          o_hold_asserted,
   output logic          o_pin_reset_active,
   // Command results, one cycle pulses
   output logic          o_write_done,
   output logic          o_write_rejected,
   output logic          o_quad_grant,
   output logic          o_quad_refuse,
   // Nonvolatile update request
   output logic          o_nv_write,
   output logic          o_nv_protect_upper,
   output logic          o_nv_protect_lower
);

   typedef struct packed {
      cmd_state_t    state;
      logic [7:0]    opcode;
      logic [7:0]    data0;
      logic [7:0]    data1;
      logic          two_bytes;
      logic [1:0]    reg_sel;
      logic          write_enable_latch;
      logic [7:0]    sr2;
      logic          protect_lower;
      logic          hold_fn;
      logic          perm_lock;
      protect_type_t ptype;
      logic          hold_asserted;
      logic          pin_reset;
      logic          write_done;
      logic          write_rejected;
      logic          quad_grant;
      logic          quad_refuse;
      logic          nv_write;
      logic          nv_upper;
      logic          nv_lower;
   } top_state_t;

   top_state_t    st;
   top_state_t    next_st;

   logic [1:0]    pins_sync;
   logic          wp_sync_n;
   logic          hold_sync_n;
   logic          quad_on;
   logic          wp_level;
   protect_type_t dec_type;
   logic          dec_write_ok;
   logic          wr_sr1;
   logic          wr_sr2;
   logic          wr_sr3;
   logic [7:0]    val_sr1;
   logic [7:0]    val_sr2;
   logic [7:0]    val_sr3;
   logic [1:0]    reset_bits;

   // Pins are asynchronous to the command clock
   pin_sync #(
      .WIDTH     (2),
      .RESET_VAL (2'h3)
   ) u_pin_sync (
      .i_clock (i_clock),
      .i_srst  (i_srst),
      .i_async ({i_hold_reset_n, i_wp_n}),
      .o_sync  (pins_sync)
   );

   assign wp_sync_n   = pins_sync[0];
   assign hold_sync_n = pins_sync[1];
   assign quad_on     = st.sr2[SR2_QUAD_ENABLE_POS];

   // With quad on the pin carries data, so it can no longer protect
   assign wp_level = quad_on ? 1'b1 : wp_sync_n;

   // Decode from the live volatile bits, not the stored copy
   protect_decoder u_decoder (
      .i_protect_upper  (st.sr2[SR2_PROTECT_UPPER_POS]),
      .i_protect_lower  (st.protect_lower),
      .i_permanent_lock (st.perm_lock),
      .i_wp_level       (wp_level),
      .o_type           (dec_type),
      .o_write_ok       (dec_write_ok)
   );

   // Which registers a write touches, and with what
   always_comb begin
      wr_sr1  = 1'b0;
      wr_sr2  = 1'b0;
      wr_sr3  = 1'b0;
      val_sr1 = st.data0;
      val_sr2 = st.data0;
      val_sr3 = st.data0;
      case (st.opcode)
         OP_WRITE_SR1: begin
            wr_sr1  = 1'b1;
            wr_sr2  = st.two_bytes;
            val_sr2 = st.data1;
         end
         OP_WRITE_SR2: wr_sr2 = 1'b1;
         OP_WRITE_SR3: wr_sr3 = 1'b1;
         OP_WRITE_SR_ANY: begin
            wr_sr1 = (st.reg_sel == SEL_SR1);
            wr_sr2 = (st.reg_sel == SEL_SR2);
            wr_sr3 = (st.reg_sel == SEL_SR3);
         end
         default: begin
            wr_sr1 = 1'b0;
         end
      endcase
   end

   assign reset_bits = reset_map(i_nv_protect_upper, i_nv_protect_lower,
                                 i_nv_permanent_lock);

   // Command sequencing, pin roles and reset load
   always_comb begin
      next_st                = st;
      next_st.write_done     = 1'b0;
      next_st.write_rejected = 1'b0;
      next_st.quad_grant     = 1'b0;
      next_st.quad_refuse    = 1'b0;
      next_st.nv_write       = 1'b0;
      next_st.ptype          = dec_type;
      // Hold and reset roles only while quad is off
      next_st.hold_asserted  = !quad_on && !st.hold_fn && !hold_sync_n;
      next_st.pin_reset      = !quad_on && st.hold_fn && !hold_sync_n;
      case (st.state)
         st_idle: begin
            // Other opcodes are not this block's business
            if (i_cmd_valid && (is_status_write(i_cmd_opcode) ||
                                is_quad_cmd(i_cmd_opcode))) begin
               next_st.state     = st_decide;
               next_st.opcode    = i_cmd_opcode;
               next_st.data0     = i_cmd_data0;
               next_st.data1     = i_cmd_data1;
               next_st.two_bytes = i_cmd_two_bytes;
               next_st.reg_sel   = i_cmd_reg_sel;
               next_st.write_enable_latch       = i_write_enable_latch;
            end
         end
         st_decide: begin
            next_st.state = st_idle;
            if (is_quad_cmd(st.opcode)) begin
               next_st.quad_grant  = quad_on;
               next_st.quad_refuse = !quad_on;
            end else if (st.write_enable_latch && dec_write_ok) begin
               // Accepted write, only the listed registers change
               if (wr_sr1) begin
                  next_st.protect_lower = val_sr1[SR1_PROTECT_LOWER_POS];
               end
               if (wr_sr2) begin
                  next_st.sr2 = val_sr2 & SR2_WRITE_MASK;
               end
               if (wr_sr3) begin
                  next_st.hold_fn = val_sr3[SR3_HOLD_RESET_POS];
               end
               next_st.write_done = 1'b1;
               next_st.nv_write   = wr_sr1 || wr_sr2;
               next_st.nv_upper   = next_st.sr2[SR2_PROTECT_UPPER_POS];
               next_st.nv_lower   = next_st.protect_lower;
            end else begin
               // Refused: nothing moves but the pulse
               next_st.write_rejected = 1'b1;
            end
         end
         default: next_st.state = st_idle;
      endcase
      if (i_srst) begin
         next_st                = '0;
         next_st.state          = st_idle;
         next_st.ptype          = pt_software;
         next_st.sr2            = SR2_RESET_VALUE;
         next_st.hold_fn        = HOLD_FN_RESET;
         next_st.perm_lock      = i_nv_permanent_lock;
         // Lockdown ends here; permanent lock survives
         next_st.sr2[SR2_PROTECT_UPPER_POS] = reset_bits[1];
         next_st.protect_lower  = reset_bits[0];
      end
   end

   always_ff @(posedge i_clock) begin
      st <= next_st;
   end

   // Every output is a field of the state register
   assign o_status2             = st.sr2;
   assign o_quad_io_enable      = st.sr2[SR2_QUAD_ENABLE_POS];
   assign o_reg_protect_upper   = st.sr2[SR2_PROTECT_UPPER_POS];
   assign o_reg_protect_lower   = st.protect_lower;
   assign o_permanent_lock_flag = st.perm_lock;
   assign o_hold_reset_select   = st.hold_fn;
   assign o_protect_type        = st.ptype;
   assign o_hold_asserted       = st.hold_asserted;
   assign o_pin_reset_active    = st.pin_reset;
   assign o_write_done          = st.write_done;
   assign o_write_rejected      = st.write_rejected;
   assign o_quad_grant          = st.quad_grant;
   assign o_quad_refuse         = st.quad_refuse;
   assign o_nv_write            = st.nv_write;
   assign o_nv_protect_upper    = st.nv_upper;
   assign o_nv_protect_lower    = st.nv_lower;

   // Checks on the protection behaviour
   logic decide_write;
   assign decide_write = (st.state == st_decide) && !is_quad_cmd(st.opcode);

   property p_qe_follows_write;
      @(posedge i_clock) disable iff (i_srst)
      (decide_write && st.write_enable_latch && dec_write_ok && wr_sr2) |=>
         o_quad_io_enable == $past(val_sr2[SR2_QUAD_ENABLE_POS]);
   endproperty
   a_qe_follows_write: assert property (p_qe_follows_write)
      else $error("quad enable did not take the written value");

   property p_quad_kills_pin_roles;
      @(posedge i_clock) disable iff (i_srst)
      (o_quad_io_enable && $stable(o_quad_io_enable)) |->
         !o_hold_asserted && !o_pin_reset_active;
   endproperty
   a_quad_kills_pin_roles: assert property (p_quad_kills_pin_roles)
      else $error("hold or reset role active with quad enabled");

   property p_quad_gate;
      @(posedge i_clock) disable iff (i_srst)
      (st.state == st_idle && i_cmd_valid && is_quad_cmd(i_cmd_opcode)) |->
         ##2 (o_quad_grant == $past(o_quad_io_enable)) &&
             (o_quad_refuse != o_quad_grant);
   endproperty
   a_quad_gate: assert property (p_quad_gate)
      else $error("quad command not gated by quad enable");

   property p_no_refuse_other;
      @(posedge i_clock) disable iff (i_srst)
      (st.state == st_idle && i_cmd_valid && !is_quad_cmd(i_cmd_opcode)) |->
         ##2 !o_quad_refuse && !o_quad_grant;
   endproperty
   a_no_refuse_other: assert property (p_no_refuse_other)
      else $error("quad gate answered a non quad command");

   property p_hw_protect_refuses;
      @(posedge i_clock) disable iff (i_srst)
      (decide_write && dec_type == pt_hw_protected) |=>
         o_write_rejected && !o_write_done;
   endproperty
   a_hw_protect_refuses: assert property (p_hw_protect_refuses)
      else $error("write accepted while pin protected");

   property p_open_accepts;
      @(posedge i_clock) disable iff (i_srst)
      (decide_write && st.write_enable_latch &&
       (dec_type == pt_software || dec_type == pt_hw_unprotected)) |=>
         o_write_done && !o_write_rejected;
   endproperty
   a_open_accepts: assert property (p_open_accepts)
      else $error("enabled write refused while unprotected");

   property p_lock_refuses;
      @(posedge i_clock) disable iff (i_srst)
      (decide_write && (dec_type == pt_reset_lockdown ||
                        dec_type == pt_otp)) |=>
         o_write_rejected && $stable(o_status2) &&
         $stable(o_reg_protect_lower);
   endproperty
   a_lock_refuses: assert property (p_lock_refuses)
      else $error("write got through a lockdown");

   property p_reject_no_effect;
      @(posedge i_clock) disable iff (i_srst)
      o_write_rejected |-> $stable(o_status2) && !o_nv_write &&
         $stable(o_reg_protect_lower) && $stable(o_hold_reset_select);
   endproperty
   a_reject_no_effect: assert property (p_reject_no_effect)
      else $error("refused write changed state");

   property p_reset_map;
      @(posedge i_clock)
      i_srst |=> {o_reg_protect_upper, o_reg_protect_lower} ==
         reset_map($past(i_nv_protect_upper), $past(i_nv_protect_lower),
                   $past(i_nv_permanent_lock));
   endproperty
   a_reset_map: assert property (p_reset_map)
      else $error("volatile protect bits wrong after reset");

   property p_lockdown_ends;
      @(posedge i_clock)
      (i_srst && i_nv_protect_upper && !i_nv_protect_lower) |=>
         !o_reg_protect_upper && !o_reg_protect_lower;
   endproperty
   a_lockdown_ends: assert property (p_lockdown_ends)
      else $error("reset did not end lockdown");

   property p_otp_survives;
      @(posedge i_clock)
      (i_srst && i_nv_protect_upper && i_nv_protect_lower &&
       i_nv_permanent_lock) |=>
         o_reg_protect_upper && o_reg_protect_lower && o_permanent_lock_flag;
   endproperty
   a_otp_survives: assert property (p_otp_survives)
      else $error("permanent lock lifted by reset");

   c_write_done: cover property (@(posedge i_clock) o_write_done);
   c_otp_reject: cover property (@(posedge i_clock)
      o_write_rejected && o_protect_type == pt_otp);
   c_quad_grant: cover property (@(posedge i_clock) o_quad_grant);
   c_hw_reject: cover property (@(posedge i_clock)
      o_write_rejected && o_protect_type == pt_hw_protected);

endmodule : status_reg_write_protection

/* File: rtl/flash_protect_pkg.sv */
// Purpose: Shared constants, types and decode helpers for the status
//          register protection and quad enable logic.
// Assumes: Commands arrive already decoded from the serial front end.
// Notes:   Opcodes and bit positions are those of the flash command set.
package flash_protect_pkg;

   // Command opcodes governed by the quad enable bit
   localparam logic [7:0] OP_QUAD_OUT_READ  = 8'h6b;
   localparam logic [7:0] OP_XIP_READ       = 8'heb;
   localparam logic [7:0] OP_XIP_READ_DWORD = 8'he7;
   localparam logic [7:0] OP_QUAD_PAGE_PROG = 8'h32;
   localparam logic [7:0] OP_SET_BURST_WRAP = 8'h77;
   localparam logic [7:0] OP_QUAD_READ_ID   = 8'h94;

   // Status register write opcodes
   localparam logic [7:0] OP_WRITE_SR1      = 8'h01;
   localparam logic [7:0] OP_WRITE_SR2      = 8'h31;
   localparam logic [7:0] OP_WRITE_SR3      = 8'h11;
   localparam logic [7:0] OP_WRITE_SR_ANY   = 8'h71;

   // Field positions
   localparam int SR1_PROTECT_LOWER_POS = 7;
   localparam int SR2_COMPLEMENT_POS    = 6;
   localparam int SR2_QUAD_ENABLE_POS   = 1;
   localparam int SR2_PROTECT_UPPER_POS = 0;
   localparam int SR3_HOLD_RESET_POS    = 7;

   // Writable bits of the second status register, the rest read as zero
   localparam logic [7:0] SR2_WRITE_MASK    = 8'h43;
   localparam logic [7:0] SR2_RESET_VALUE   = 8'h00;
   localparam logic       HOLD_FN_RESET     = 1'b0;

   // Register select codes of the indirect write
   localparam logic [1:0] SEL_SR1 = 2'h1;
   localparam logic [1:0] SEL_SR2 = 2'h2;
   localparam logic [1:0] SEL_SR3 = 2'h3;

   typedef enum logic [2:0] {
      pt_software,
      pt_hw_protected,
      pt_hw_unprotected,
      pt_reset_lockdown,
      pt_otp
   } protect_type_t;

   typedef enum logic {st_idle, st_decide} cmd_state_t;

   function automatic logic is_quad_cmd(input logic [7:0] op);
      return op == OP_QUAD_OUT_READ || op == OP_XIP_READ ||
             op == OP_XIP_READ_DWORD || op == OP_QUAD_PAGE_PROG ||
             op == OP_SET_BURST_WRAP || op == OP_QUAD_READ_ID;
   endfunction : is_quad_cmd

   function automatic logic is_status_write(input logic [7:0] op);
      return op == OP_WRITE_SR1 || op == OP_WRITE_SR2 ||
             op == OP_WRITE_SR3 || op == OP_WRITE_SR_ANY;
   endfunction : is_status_write

   // Volatile {upper, lower} loaded from the nonvolatile copy at reset
   function automatic logic [1:0] reset_map(input logic up,
                                            input logic lo,
                                            input logic lock);
      case ({up, lo})
         2'b00:   return 2'b00;
         2'b01:   return 2'b01;
         2'b10:   return 2'b00;
         2'b11:   return lock ? 2'b11 : 2'b01;
         default: return 2'b00;
      endcase
   endfunction : reset_map

endpackage : flash_protect_pkg

/* File: rtl/pin_sync.sv */
// Purpose: Two flop synchroniser for asynchronous pin levels.
// Assumes: Pins change slowly compared with the clock.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/10ps
module pin_sync #(
   parameter int               WIDTH     = 2,
   parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
   // Clock and reset
   input  wire logic             i_clock,
   input  wire logic             i_srst,
   // Pin side
   input  wire logic [WIDTH-1:0] i_async,
   // Synchronised side
   output logic      [WIDTH-1:0] o_sync
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_state_t;

   sync_state_t st;
   sync_state_t next_st;

   // Shift the pins through both stages; reset parks them inactive
   always_comb begin
      next_st.meta   = i_async;
      next_st.stable = st.meta;
      if (i_srst) begin
         next_st.meta   = RESET_VAL;
         next_st.stable = RESET_VAL;
      end
   end

   always_ff @(posedge i_clock) begin
      st <= next_st;
   end

   assign o_sync = st.stable;

endmodule : pin_sync

/* File: rtl/protect_decoder.sv */
// Purpose: Decode the protect bits and write protect level into a
//          protection type and a write permission.
// Assumes: Inputs are the volatile copies and a synchronised pin.
// Notes:   Purely combinational; the caller registers the type, not the write permission.
`timescale 1ns/10ps
module protect_decoder
   import flash_protect_pkg::*;
(
   // Volatile protect state
   input  wire logic    i_protect_upper,
   input  wire logic    i_protect_lower,
   input  wire logic    i_permanent_lock,
   // Effective write protect level, low protects
   input  wire logic    i_wp_level,
   // Decoded result
   output protect_type_t o_type,
   output logic          o_write_ok
);

   // Lockdown and permanent lock both refuse; only a reset tells them apart
   always_comb begin
      case ({i_protect_upper, i_protect_lower})
         2'b00:   o_type = pt_software;
         2'b01:   o_type = i_wp_level ? pt_hw_unprotected : pt_hw_protected;
         2'b10:   o_type = pt_reset_lockdown;
         2'b11:   o_type = i_permanent_lock ? pt_otp : pt_reset_lockdown;
         default: o_type = pt_reset_lockdown;
      endcase
      o_write_ok = (o_type == pt_software) || (o_type == pt_hw_unprotected);
   end

endmodule : protect_decoder

/* File: test/cmd_host.sv */
// Purpose: Serial front end model that hands decoded commands to the block.
// Assumes: Driven from the bench on falling edges only.
// Notes:   Released fields show the inverse of the last value.
`timescale 1ns/10ps
module cmd_host (
   // Clock
   input  wire logic i_clock,
   // Command results
   input  wire logic i_done,
   input  wire logic i_rejected,
   // Command to the block
   output logic       o_valid,
   output logic [7:0] o_opcode,
   output logic [7:0] o_data0,
   output logic [1:0] o_reg_sel,
   output logic       o_wel
);
   initial begin
      o_valid   = 1'b0;
      o_opcode  = 8'h00;
      o_data0   = 8'h00;
      o_reg_sel = 2'h0;
      o_wel     = 1'b0;
   end

   // One cycle command, then fields go stale so nothing is reused
   task automatic issue(input logic [7:0] op, input logic [7:0] d0,
                        input logic [1:0] sel, input logic write_enable_latch);
      @(negedge i_clock);
      o_wel     = write_enable_latch;
      o_valid   = 1'b1;
      o_opcode  = op;
      o_data0   = d0;
      o_reg_sel = sel;
      @(negedge i_clock);
      o_valid   = 1'b0;
      o_opcode  = ~op;
      o_data0   = ~d0;
      o_reg_sel = ~sel;
      @(negedge i_clock);
      // Front end drops the latch once a write is done or rejected
      if (i_done || i_rejected) begin
         o_wel = 1'b0;
      end
   endtask : issue
endmodule : cmd_host

/* File: test/testbench.sv */
// Purpose: Self-checking bench for quad enable and register protection.
// Assumes: Outcome pulses land one rising edge after the command is taken.
// Notes:   Ordinary commands come from a row table, odd cases follow.
`timescale 1ns/10ps
module testbench;
   import flash_protect_pkg::*;
   typedef struct packed {
      logic [7:0] op;
      logic [7:0] d0;
      logic [1:0] sel;
      logic       write_enable_latch;
      logic [3:0] res;
      logic [7:0] s2;
      logic       lo;
   } row_t;
   logic clock = 1'b0, srst = 1'b1, wp_n = 1'b1, hold_reset_n = 1'b1;
   logic nv_up = 1'b0, nv_lo = 1'b0, nv_lock = 1'b0;
   logic       valid, write_enable_latch, done, rej, grant, refuse, quad, upper, lower;
   logic       hold_on, hold_sel, pin_rst, perm, nv_wr, nv_wr_up, nv_wr_lo;
   logic       two_bytes = 1'b0;
   logic [7:0] data1 = 8'h00;
   logic [7:0] opcode, data0, status2;
   logic [1:0] reg_sel;
   protect_type_t ptype;
   int error_cnt = 0, num_checks = 0;
   // Result code is done, reject, grant, refuse from high to low
   row_t rows [13] = '{
      '{8'h31, 8'h02, 2'h0, 1'b1, 4'h8, 8'h02, 1'b0},
      '{8'h6b, 8'h00, 2'h0, 1'b0, 4'h2, 8'h02, 1'b0},
      '{8'heb, 8'h00, 2'h0, 1'b0, 4'h2, 8'h02, 1'b0},
      '{8'he7, 8'h00, 2'h0, 1'b0, 4'h2, 8'h02, 1'b0},
      '{8'h32, 8'h00, 2'h0, 1'b0, 4'h2, 8'h02, 1'b0},
      '{8'h77, 8'h00, 2'h0, 1'b0, 4'h2, 8'h02, 1'b0},
      '{8'h94, 8'h00, 2'h0, 1'b0, 4'h2, 8'h02, 1'b0},
      '{8'h31, 8'h00, 2'h0, 1'b0, 4'h4, 8'h02, 1'b0},
      '{8'h71, 8'h00, 2'h2, 1'b1, 4'h8, 8'h00, 1'b0},
      '{8'h94, 8'h00, 2'h0, 1'b0, 4'h1, 8'h00, 1'b0},
      '{8'h01, 8'h80, 2'h0, 1'b1, 4'h8, 8'h00, 1'b1},
      '{8'h11, 8'h00, 2'h0, 1'b1, 4'h8, 8'h00, 1'b1},
      '{8'h71, 8'h00, 2'h0, 1'b1, 4'h8, 8'h00, 1'b1}};
   // Stored {upper, lower, lock} and the volatile pair expected after
   logic [2:0] nv_in  [5] = '{3'b000, 3'b010, 3'b100, 3'b110, 3'b111};
   logic [1:0] nv_out [5] = '{2'b00, 2'b01, 2'b00, 2'b01, 2'b11};

   // Free running clock, 8 ns period
   always #4 clock = ~clock;

   cmd_host host (.i_clock(clock), .i_done(done), .i_rejected(rej),
      .o_valid(valid), .o_opcode(opcode), .o_data0(data0),
      .o_reg_sel(reg_sel), .o_wel(write_enable_latch));

   status_reg_write_protection DUT (.i_clock(clock), .i_srst(srst),
      .i_wp_n(wp_n), .i_hold_reset_n(hold_reset_n), .i_cmd_valid(valid),
      .i_cmd_opcode(opcode), .i_cmd_data0(data0), .i_cmd_data1(data1),
      .i_cmd_two_bytes(two_bytes), .i_cmd_reg_sel(reg_sel),
      .i_write_enable_latch(write_enable_latch), .i_nv_protect_upper(nv_up),
      .i_nv_protect_lower(nv_lo), .i_nv_permanent_lock(nv_lock),
      .o_status2(status2), .o_quad_io_enable(quad),
      .o_reg_protect_upper(upper), .o_reg_protect_lower(lower),
      .o_permanent_lock_flag(perm), .o_hold_reset_select(hold_sel),
      .o_protect_type(ptype), .o_hold_asserted(hold_on),
      .o_pin_reset_active(pin_rst), .o_write_done(done),
      .o_write_rejected(rej), .o_quad_grant(grant),
      .o_quad_refuse(refuse), .o_nv_write(nv_wr),
      .o_nv_protect_upper(nv_wr_up), .o_nv_protect_lower(nv_wr_lo));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Issue one command and look at the pulses in the cycle they stand
   task automatic step(input row_t r);
      host.issue(r.op, r.d0, r.sel, r.write_enable_latch);
      chk({4'h0, done, rej, grant, refuse}, {4'h0, r.res});
      chk(status2, r.s2);
      chk({7'h0, lower}, {7'h0, r.lo});
   endtask : step

   // Reset held two cycles; stands for power cycle, pin or soft reset
   task automatic rst(input logic [2:0] nv);
      @(negedge clock);
      {nv_up, nv_lo, nv_lock} = nv;
      srst = 1'b1;
      repeat (2) @(negedge clock);
      srst = 1'b0;
   endtask : rst

   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : summarize

   // Whole run is about 110 cycles; this cuts a hang short
   initial begin
      #16000;
      error_cnt++;
      summarize();
   end

   initial begin
      rst(3'b000);
      chk(status2, 8'h00);
      chk({7'h0, upper}, 8'h00);
      $display("test reset done");
      foreach (rows[i]) step(rows[i]);
      $display("test rows done");
      // Protect pin low with lower bit set; hold pin low too
      wp_n = 1'b0;
      hold_reset_n = 1'b0;
      repeat (5) @(negedge clock);
      chk({7'h0, hold_on}, 8'h01);
      step('{8'h31, 8'h03, 2'h0, 1'b1, 4'h4, 8'h00, 1'b1});
      wp_n = 1'b1;
      repeat (5) @(negedge clock);
      step('{8'h31, 8'h03, 2'h0, 1'b1, 4'h8, 8'h03, 1'b1});
      @(negedge clock);
      chk({7'h0, hold_on}, 8'h00);
      chk(8'(ptype), 8'(pt_reset_lockdown));
      step('{8'h31, 8'h00, 2'h0, 1'b1, 4'h4, 8'h03, 1'b1});
      hold_reset_n = 1'b1;
      $display("test pins done");
      foreach (nv_in[i]) begin
         rst(nv_in[i]);
         chk({5'h0, perm, upper, lower},
             {5'h0, nv_in[i][0], nv_out[i]});
      end
      step('{8'h31, 8'h00, 2'h0, 1'b1, 4'h4, 8'h01, 1'b1});
      rst(3'b000);
      chk({6'h0, upper, lower}, 8'h00);
      step('{8'h31, 8'h01, 2'h0, 1'b1, 4'h8, 8'h01, 1'b0});
      step('{8'h31, 8'h00, 2'h0, 1'b1, 4'h4, 8'h01, 1'b0});
      rst(3'b000);
      step('{8'h31, 8'h00, 2'h0, 1'b1, 4'h8, 8'h00, 1'b0});
      $display("test lock done");
      // Protect pin low means nothing while both protect bits are clear
      wp_n = 1'b0;
      hold_reset_n = 1'b0;
      repeat (5) @(negedge clock);
      step('{8'h71, 8'h80, 2'h3, 1'b1, 4'h8, 8'h00, 1'b0});
      @(negedge clock);
      chk({5'h0, hold_sel, pin_rst, hold_on}, 8'h06);
      hold_reset_n = 1'b1;
      // Second byte reaches the second register through its write mask
      two_bytes = 1'b1;
      data1 = 8'hbe;
      step('{8'h01, 8'h80, 2'h0, 1'b1, 4'h8, 8'h02, 1'b1});
      chk({5'h0, nv_wr, nv_wr_up, nv_wr_lo}, 8'h05);
      two_bytes = 1'b0;
      // Quad on turns the low protect pin into data, so writes go through
      step('{8'h71, 8'h00, 2'h1, 1'b1, 4'h8, 8'h02, 1'b0});
      $display("test extras done");
      summarize();
   end
endmodule : testbench
